/* File: vfd_drv_defs.svh */
`ifndef VFD_DRV_DEFS_SVH
`define VFD_DRV_DEFS_SVH
// Function
// (RQ1) Ten stage register feeds ten latches
// (RQ2) Rising shift clock captures serial input
// (RQ3) Each rising edge moves data one stage
// (RQ4) Host sets data before raising shift clock
// (RQ5) Strobe high copies register into latches
// (RQ6) Latches follow while high, hold when low
// (RQ7) Blanking high forces all outputs low
// (RQ8) Blanking never alters latch contents
// (RQ9) Unblanked output follows its latch
// (RQ10) Last stage drives serial output
// (RQ11) Strobe tied high needs blanking during entry
// (RQ12) Host keeps shift clock within rated rate
// (RQ13) No shift edge, stages and output hold

// Channel count and reset values
`define CHAN_COUNT      10
`define SHIFT_RESET     10'h000
`define LATCH_RESET     10'h000

// Host shift clock limit: 3.3 MHz, as a least period
`define SCLK_MIN_PERIOD_NS 303
`define CLK_PERIOD_NS      5
`define SCLK_MIN_CYC ((`SCLK_MIN_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SPACE_CNT_W        7
`endif

/* File: vfd_drv_pkg.sv */
`include "vfd_drv_defs.svh"
package vfd_drv_pkg;
    // One bit per output channel
    typedef logic [`CHAN_COUNT-1:0] chan_t;
    // Cycles since the last shift edge
    typedef logic [`SPACE_CNT_W-1:0] space_t;
endpackage

/* File: serial_latched_driver.sv */
`timescale 1ns/100ps
`include "vfd_drv_defs.svh"
module serial_latched_driver #(
    parameter int N = `CHAN_COUNT
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // Host serial pins, asynchronous to clk
    input  wire logic               serialIn,
    input  wire logic               shiftClk,
    input  wire logic               strobe,
    input  wire logic               blank_pin,
    // Cascade output
    output logic                    serialOut,
    // Output stage, one bit per channel
    output vfd_drv_pkg::chan_t      outLevel,
    output vfd_drv_pkg::chan_t      sourceOn,
    output vfd_drv_pkg::chan_t      sinkOn,
    // Host misuse indicators
    output logic                    rateFault,
    output logic                    entryHazard
);
    import vfd_drv_pkg::*;

    localparam space_t SPACE_MIN = space_t'(`SCLK_MIN_CYC);

    // Pin synchronisers, two flops before any use
    logic   dataSync1_reg,  dataSync1_next;
    logic   dataSync2_reg,  dataSync2_next;
    logic   sclkSync1_reg,  sclkSync1_next;
    logic   sclkSync2_reg,  sclkSync2_next;
    logic   sclkPrev_reg,   sclkPrev_next;
    logic   strbSync1_reg,  strbSync1_next;
    logic   strbSync2_reg,  strbSync2_next;
    logic   blnkSync1_reg,  blnkSync1_next;
    logic   blnkSync2_reg,  blnkSync2_next;
    logic   shiftEdge;

    // Core state
    chan_t  shift_reg,      shift_next;
    chan_t  latch_reg,      latch_next;
    chan_t  out_reg,        out_next;
    logic   sout_reg,       sout_next;

    // Rate and entry hazard monitor
    space_t space_reg,      space_next;
    logic   fault_reg,      fault_next;
    logic   hazard_reg,     hazard_next;

    // Synchroniser next values
    always_comb begin
        dataSync1_next = serialIn;
        dataSync2_next = dataSync1_reg;
        sclkSync1_next = shiftClk;
        sclkSync2_next = sclkSync1_reg;
        sclkPrev_next  = sclkSync2_reg;
        strbSync1_next = strobe;
        strbSync2_next = strbSync1_reg;
        blnkSync1_next = blank_pin;
        blnkSync2_next = blnkSync1_reg;
    end

    // Synchroniser flops; resets idle the pins low
    always_ff @(posedge clk) begin
        if (rst) begin
            dataSync1_reg <= 1'b0;
            dataSync2_reg <= 1'b0;
            sclkSync1_reg <= 1'b0;
            sclkSync2_reg <= 1'b0;
            sclkPrev_reg  <= 1'b0;
            strbSync1_reg <= 1'b0;
            strbSync2_reg <= 1'b0;
            blnkSync1_reg <= 1'b0;
            blnkSync2_reg <= 1'b0;
        end else begin
            dataSync1_reg <= dataSync1_next;
            dataSync2_reg <= dataSync2_next;
            sclkSync1_reg <= sclkSync1_next;
            sclkSync2_reg <= sclkSync2_next;
            sclkPrev_reg  <= sclkPrev_next;
            strbSync1_reg <= strbSync1_next;
            strbSync2_reg <= strbSync2_next;
            blnkSync1_reg <= blnkSync1_next;
            blnkSync2_reg <= blnkSync2_next;
        end
    end

    // Low-to-high shift clock, seen after synchronising
    assign shiftEdge = sclkSync2_reg & ~sclkPrev_reg;                 // see (RQ2)

    // Shift register, latches and output stage
    always_comb begin
        shift_next = shift_reg;                                       // see (RQ13)
        sout_next  = sout_reg;
        if (shiftEdge) begin
            // Data and clock pass equal sync depth, so setup holds
            shift_next = {shift_reg[N-2:0], dataSync2_reg};           // see (RQ2) (RQ3) (RQ4)
            sout_next  = shift_reg[N-2];                              // see (RQ10)
        end
        // Transparent while high, one cycle behind the register
        latch_next = strbSync2_reg ? shift_reg : latch_reg;           // see (RQ5) (RQ6) (RQ8)
        // Blanking gates only the output stage
        out_next = blnkSync2_reg ? '0 : latch_next;                   // see (RQ7) (RQ9)
    end

    // Per-channel state flops
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : gChan
            always_ff @(posedge clk) begin
                if (rst) begin
                    shift_reg[g] <= 1'b0;
                    latch_reg[g] <= 1'b0;
                    out_reg[g]   <= 1'b0;
                end else begin
                    shift_reg[g] <= shift_next[g];                    // see (RQ1)
                    latch_reg[g] <= latch_next[g];
                    out_reg[g]   <= out_next[g];
                end
            end
        end
    endgenerate

    // Cascade output flop
    always_ff @(posedge clk) begin
        if (rst) begin
            sout_reg <= 1'b0;
        end else begin
            sout_reg <= sout_next;
        end
    end

    // Host misuse monitor; it flags, it never blocks a shift
    always_comb begin
        space_next  = space_reg;
        fault_next  = 1'b0;
        hazard_next = 1'b0;
        if (shiftEdge) begin
            space_next  = '0;
            fault_next  = (space_reg < SPACE_MIN);                    // see (RQ12)
            // Latches open and outputs live while data moves
            hazard_next = strbSync2_reg & ~blnkSync2_reg;             // see (RQ11)
        end else if (space_reg != SPACE_MIN) begin
            space_next = space_reg + space_t'(1);
        end
    end

    // Monitor flops; start saturated so the first edge is clean
    always_ff @(posedge clk) begin
        if (rst) begin
            space_reg  <= space_t'(`SCLK_MIN_CYC);
            fault_reg  <= 1'b0;
            hazard_reg <= 1'b0;
        end else begin
            space_reg  <= space_next;
            fault_reg  <= fault_next;
            hazard_reg <= hazard_next;
        end
    end

    // Outputs, all from flops
    assign serialOut   = sout_reg;                                    // see (RQ10)
    assign outLevel    = out_reg;
    assign sourceOn    = out_reg;                                     // see (RQ7)
    assign sinkOn      = ~out_reg;                                    // see (RQ7)
    assign rateFault   = fault_reg;
    assign entryHazard = hazard_reg;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Pin rise reaches the register three edges later
    sequence sClkRise;
        !shiftClk ##1 shiftClk [*3];
    endsequence

    sequence sStrobeHeld;
        strbSync2_reg [*2];
    endsequence

    a_first_stage_cap: assert property (                              // see (RQ2)
        shiftEdge |=> shift_reg[0] == $past(dataSync2_reg))
        else $error("First stage missed the serial input");

    a_stage_shift_on: assert property (                               // see (RQ3)
        shiftEdge |=> shift_reg[N-1:1] == $past(shift_reg[N-2:0]))
        else $error("Stages did not move one place");

    a_pin_to_shift: assert property (                                 // see (RQ2)
        sClkRise |-> shiftEdge)
        else $error("Shift clock rise not seen after sync");

    a_hold_no_edge: assert property (                                 // see (RQ13)
        !shiftEdge |=> $stable(shift_reg) && $stable(serialOut))
        else $error("Register moved without a shift edge");

    a_latch_follow: assert property (                                 // see (RQ5) (RQ6)
        sStrobeHeld |-> latch_reg == $past(shift_reg))
        else $error("Latch not transparent under strobe");

    a_latch_hold: assert property (                                   // see (RQ6) (RQ8)
        !strbSync2_reg |=> $stable(latch_reg))
        else $error("Latch changed with strobe low");

    a_blank_forces: assert property (                                 // see (RQ7)
        blnkSync2_reg [*2] |-> outLevel == '0 && sinkOn == '1)
        else $error("Outputs not forced low by blanking");

    a_out_follows: assert property (                                  // see (RQ9)
        !blnkSync2_reg |=> outLevel == latch_reg)
        else $error("Unblanked output differs from latch");

    a_serial_tail: assert property (                                  // see (RQ10)
        shiftEdge |=> serialOut == shift_reg[N-1])
        else $error("Serial output not the last stage");

    a_rate_flag: assert property (                                    // see (RQ12)
        shiftEdge && space_reg < SPACE_MIN |=> rateFault)
        else $error("Fast shift clock not flagged");

endmodule

/* File: host_model.sv */
`timescale 1ns/100ps
module host_model (
    // Clock
    input  wire logic clk,
    // Host pins
    output logic      serialIn,
    output logic      shiftClk,
    output logic      strobe,
    output logic      blank_pin
);
    // Idle pins, shift clock low at reset
    initial {serialIn, shiftClk, strobe, blank_pin} = 4'h0;
    // Off the sampling edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Strobe, blanking, then wait
    task automatic set_ctrl(input logic s, input logic b, input int n);
        {strobe, blank_pin} = {s, b};
        tick(n);
    endtask
    // Data before rise; half of 31 keeps rate
    task automatic shift_bit(input logic d, input int half);
        serialIn = d;
        tick(half);
        shiftClk = 1'b1;
        tick(half);
        shiftClk = 1'b0;
    endtask
endmodule

/* File: tb.sv */
`timescale 1ns/100ps
module tb;
    import vfd_drv_pkg::*;
    logic clk = 1'b0, rst = 1'b1;
    logic serialIn, shiftClk, strobe, blank_pin, serialOut, rateFault, entryHazard;
    chan_t outLevel, sourceOn, sinkOn;
    int n_fail = 0, tests_run = 0;
    logic sawRate = 1'b0, sawHazard = 1'b0;
    always #2.5 clk = ~clk;
    // One-cycle flags, kept sticky
    always @(posedge clk) begin
        if (rateFault === 1'b1) sawRate <= 1'b1;
        if (entryHazard === 1'b1) sawHazard <= 1'b1;
    end
    host_model u_host_model (.clk, .serialIn, .shiftClk, .strobe, .blank_pin);
    serial_latched_driver u_serial_latched_driver (.clk, .rst, .serialIn, .shiftClk,
        .strobe, .blank_pin, .serialOut, .outLevel, .sourceOn, .sinkOn, .rateFault,
        .entryHazard);
    task automatic final_report();
        $display("checks %0d, fails %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic check_chan(input chan_t got, exp, input string m);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task automatic check_bit(input logic got, exp, input string m);
        check_chan(chan_t'(got), chan_t'(exp), m);
    endtask
    // First bit ends in bit9, old bits leave
    task automatic shift_word(input chan_t w, old, input int half);
        for (int i = 9; i >= 0; i--) begin
            check_bit(serialOut, old[i], "cascade");
            u_host_model.shift_bit(w[i], half);
        end
    endtask
    task automatic t_load(input chan_t p, old);
        shift_word(p, old, 31);
        check_chan(outLevel, old, "held latch");
        u_host_model.set_ctrl(1'b1, 1'b0, 4);
        u_host_model.set_ctrl(1'b0, 1'b0, 6);
        check_chan(outLevel, p, "latched");
        check_chan(sourceOn, p, "source");
        check_chan(sinkOn, ~p, "sink");
        check_bit(sawRate, 1'b0, "rate ok");
    endtask
    task automatic t_blank(input chan_t p);
        u_host_model.set_ctrl(1'b0, 1'b1, 6);
        check_chan(outLevel, '0, "blanked");
        check_chan(sinkOn, '1, "sinks on");
        u_host_model.set_ctrl(1'b0, 1'b0, 6);
        check_chan(outLevel, p, "unblanked");
    endtask
    // Strobe held high, blanking covers entry
    task automatic t_bypass(input chan_t p, old);
        u_host_model.set_ctrl(1'b1, 1'b1, 1);
        shift_word(p, old, 31);
        check_chan(outLevel, '0, "bypass blank");
        check_bit(sawHazard, 1'b0, "no hazard");
        u_host_model.set_ctrl(1'b1, 1'b0, 6);
        check_chan(outLevel, p, "bypass show");
    endtask
    // Fast clock, latches open: both flags
    task automatic t_misuse(input chan_t p, old);
        shift_word(p, old, 3);
        u_host_model.tick(6);
        check_bit(sawRate, 1'b1, "rate flag");
        check_bit(sawHazard, 1'b1, "hazard flag");
        check_chan(outLevel, p, "fast shift");
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        final_report();
    end
    initial begin
        u_host_model.tick(5);
        rst = 1'b0;
        u_host_model.tick(2);
        check_chan(outLevel, '0, "reset out");
        check_chan(sinkOn, '1, "reset sink");
        check_bit(serialOut, 1'b0, "reset serial");
        t_load(10'h2b5, '0);
        t_blank(10'h2b5);
        t_load(10'h14a, 10'h2b5);
        t_bypass(10'h0f3, 10'h14a);
        t_misuse(10'h301, 10'h0f3);
        final_report();
    end
endmodule
